// ### rtl/mirq_ctrl.sv
// Interrupt controller of a small microcontroller core, APB registers.
// Assumes the core sequencer pulses instruction and return strobes
// and honours vector_req by pushing its return address.
`timescale 1ns/1ps
module mirq_ctrl #(
  parameter int NUM_PERIPH = mirq_pkg::PERIPH_SRC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External sources
  input wire logic ext_irq_pin,
  input wire logic [3:0] upper_port,
  input wire logic timer_zero_wrap,
  input wire logic [NUM_PERIPH-1:0] periph_event,
  // Core sequencer
  input wire logic instr_cycle,
  input wire logic return_from_handler,
  input wire logic sleep_enter,
  input wire logic [12:0] return_pc,
  output logic vector_req,
  output logic [12:0] vector_addr,
  output logic [12:0] stack_push_pc,
  output logic wake_req,
  output logic asleep
);
  localparam int NA = NUM_PERIPH / 2;
  localparam int NB = NUM_PERIPH - NA;

  typedef struct packed {
    logic [7:0] control;
    logic [NA-1:0] flags_a;
    logic [NB-1:0] flags_b;
    logic [NA-1:0] en_a;
    logic [NB-1:0] en_b;
    logic [7:0] option;
    logic [3:0] port_last;
    logic [1:0] lat_cnt;
    logic lat_busy;
    logic in_handler;
    logic sleeping;
    logic vector;
    logic wake;
    logic [12:0] push_pc;
    logic [31:0] rdata;
  } mirq_state_t;

  mirq_state_t st_ff;
  mirq_state_t nxt_st;

  logic [0:0] ext_rise;
  logic [0:0] ext_fall;
  logic [3:0] port_lvl;
  logic ext_edge;
  logic port_change;
  logic periph_pend;
  logic ctrl_pend;
  logic any_pend;
  logic apb_wr;
  logic apb_rd;
  logic [31:0] wr_word;

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  mirq_edge_sync #(.WIDTH(1)) u_ext_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async(ext_irq_pin),
    .level(),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  mirq_edge_sync #(.WIDTH(4)) u_port_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_async(upper_port),
    .level(port_lvl),
    .rise(),
    .fall()
  );

  // --------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------
  // Edge select picks rising or falling
  assign ext_edge = st_ff.option[mirq_pkg::BIT_EDGE_SEL] ?
                    ext_rise[0] : ext_fall[0];
  // Compare against the last value software could have read
  assign port_change = port_lvl != st_ff.port_last;
  assign periph_pend = st_ff.control[mirq_pkg::BIT_PERIPH_EN] &
                       (|(st_ff.flags_a & st_ff.en_a) |
                        |(st_ff.flags_b & st_ff.en_b));
  // Sources in the control register need no peripheral enable
  assign ctrl_pend =
    (st_ff.control[mirq_pkg::BIT_EXT_FLAG] &
     st_ff.control[mirq_pkg::BIT_EXT_EN]) |
    (st_ff.control[mirq_pkg::BIT_TMR_FLAG] &
     st_ff.control[mirq_pkg::BIT_TMR_EN]) |
    (st_ff.control[mirq_pkg::BIT_PORT_FLAG] &
     st_ff.control[mirq_pkg::BIT_PORT_EN]);
  assign any_pend = ctrl_pend | periph_pend;

  // --------------------------------------------------------------
  // APB slave, zero wait states
  // --------------------------------------------------------------
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & ~penable & ~pwrite;
  assign wr_word = pwdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable &
                   (paddr > mirq_pkg::ADDR_STATUS || paddr[1:0] != 2'h0);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.vector = 1'b0;
    nxt_st.wake = 1'b0;

    // Register writes come first; hardware sets below win
    if (apb_wr) begin
      unique case (paddr)
        mirq_pkg::ADDR_CONTROL: nxt_st.control = wr_word[7:0];
        mirq_pkg::ADDR_FLAGS_A: nxt_st.flags_a = wr_word[NA-1:0];
        mirq_pkg::ADDR_FLAGS_B: nxt_st.flags_b = wr_word[NB-1:0];
        mirq_pkg::ADDR_ENABLES_A: nxt_st.en_a = wr_word[NA-1:0];
        mirq_pkg::ADDR_ENABLES_B: nxt_st.en_b = wr_word[NB-1:0];
        mirq_pkg::ADDR_OPTION: nxt_st.option = wr_word[7:0];
        default: ;
      endcase
    end

    // Reading the control register re-arms the port compare
    if (apb_rd && paddr == mirq_pkg::ADDR_CONTROL) begin
      nxt_st.port_last = port_lvl;
    end

    // Read data registered in setup, stable through access
    if (apb_rd) begin
      unique case (paddr)
        mirq_pkg::ADDR_CONTROL: nxt_st.rdata = {24'h0, st_ff.control};
        mirq_pkg::ADDR_FLAGS_A:
          nxt_st.rdata = 32'(st_ff.flags_a);
        mirq_pkg::ADDR_FLAGS_B:
          nxt_st.rdata = 32'(st_ff.flags_b);
        mirq_pkg::ADDR_ENABLES_A:
          nxt_st.rdata = 32'(st_ff.en_a);
        mirq_pkg::ADDR_ENABLES_B:
          nxt_st.rdata = 32'(st_ff.en_b);
        mirq_pkg::ADDR_OPTION: nxt_st.rdata = {24'h0, st_ff.option};
        mirq_pkg::ADDR_STATUS:
          nxt_st.rdata = {29'h0, st_ff.sleeping, st_ff.in_handler,
                          any_pend};
        default: nxt_st.rdata = 32'h0;
      endcase
    end

    // Flag sets, independent of every enable
    if (ext_edge) begin
      nxt_st.control[mirq_pkg::BIT_EXT_FLAG] = 1'b1;
    end
    if (timer_zero_wrap) begin
      nxt_st.control[mirq_pkg::BIT_TMR_FLAG] = 1'b1;
    end
    if (port_change) begin
      nxt_st.control[mirq_pkg::BIT_PORT_FLAG] = 1'b1;
    end
    nxt_st.flags_a = nxt_st.flags_a | periph_event[NA-1:0];
    nxt_st.flags_b = nxt_st.flags_b |
                     periph_event[NUM_PERIPH-1:NA];

    if (return_from_handler) begin
      nxt_st.control[mirq_pkg::BIT_GLOBAL_EN] = 1'b1;
      nxt_st.in_handler = 1'b0;
    end

    if (sleep_enter && !any_pend) begin
      nxt_st.sleeping = 1'b1;
    end

    // Enabled request wakes regardless of global enable
    if (st_ff.sleeping && any_pend) begin
      nxt_st.sleeping = 1'b0;
      nxt_st.wake = 1'b1;
    end

    // Fixed latency counted in instruction cycles; counting core strobes
    // rather than clocks keeps it equal for one- and two-cycle opcodes.
    // Arming is dropped if the request vanishes before the count ends.
    if (!st_ff.lat_busy) begin
      if (any_pend && st_ff.control[mirq_pkg::BIT_GLOBAL_EN] &&
          !st_ff.sleeping) begin
        nxt_st.lat_busy = 1'b1;
        nxt_st.lat_cnt = 2'h0;
      end
    end else if (!st_ff.control[mirq_pkg::BIT_GLOBAL_EN] || !any_pend) begin
      nxt_st.lat_busy = 1'b0;
    end else if (instr_cycle) begin
      if (st_ff.lat_cnt == mirq_pkg::LAT_CYCLES) begin
        nxt_st.lat_busy = 1'b0;
        nxt_st.vector = 1'b1;
        nxt_st.push_pc = return_pc;
        nxt_st.in_handler = 1'b1;
        nxt_st.control[mirq_pkg::BIT_GLOBAL_EN] = 1'b0;
      end else begin
        nxt_st.lat_cnt = st_ff.lat_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.control <= mirq_pkg::RST_CONTROL;
      st_ff.option <= mirq_pkg::RST_OPTION;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign prdata = st_ff.rdata;
  assign vector_req = st_ff.vector;
  assign vector_addr = mirq_pkg::IRQ_VECTOR;
  assign stack_push_pc = st_ff.push_pc;
  assign wake_req = st_ff.wake;
  assign asleep = st_ff.sleeping;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_vector_clears_global: assert property (
    vector_req |-> !st_ff.control[mirq_pkg::BIT_GLOBAL_EN])
    else $error("global enable still set after vector");
  a_vector_needs_global: assert property (
    vector_req |-> $past(st_ff.control[mirq_pkg::BIT_GLOBAL_EN]))
    else $error("vector without global enable");
  a_return_sets_global: assert property (
    return_from_handler |=> st_ff.control[mirq_pkg::BIT_GLOBAL_EN])
    else $error("return did not set global enable");
  a_ext_flag_set: assert property (
    ext_edge |=> st_ff.control[mirq_pkg::BIT_EXT_FLAG])
    else $error("pin edge lost");
  a_timer_flag_set: assert property (
    timer_zero_wrap |=> st_ff.control[mirq_pkg::BIT_TMR_FLAG])
    else $error("timer wrap lost");
  a_port_flag_set: assert property (
    port_change |=> st_ff.control[mirq_pkg::BIT_PORT_FLAG])
    else $error("port change lost");
  a_periph_flag_set: assert property (
    periph_event[0] |=> st_ff.flags_a[0])
    else $error("peripheral event lost");
  a_wake_has_flag: assert property (
    wake_req |-> any_pend)
    else $error("wake without flag");
  a_vector_push_pc: assert property (
    vector_req |-> stack_push_pc == $past(return_pc))
    else $error("wrong return address");
  a_periph_gate: assert property (
    vector_req && !$past(st_ff.control[mirq_pkg::BIT_PERIPH_EN]) |->
      $past(ctrl_pend))
    else $error("peripheral passes without its enable");
  a_reset_clears_global: assert property (
    $fell(reset) |-> !st_ff.control[mirq_pkg::BIT_GLOBAL_EN])
    else $error("global enable set after reset");
  a_vector_one_cycle: assert property (
    vector_req |=> !vector_req)
    else $error("vector request longer than one cycle");
  a_sleep_no_vector: assert property (
    asleep |-> !vector_req)
    else $error("vector while asleep");
  a_push_pc_held: assert property (
    !vector_req && !$past(reset) |-> $stable(stack_push_pc))
    else $error("pushed address moved without vector");
  a_wake_ends_sleep: assert property (
    wake_req |-> !asleep)
    else $error("still asleep after wake");

  c_vector: cover property (vector_req);
  c_wake: cover property (wake_req);
  c_return: cover property (return_from_handler ##1 vector_req);
  c_wake_vector: cover property (wake_req ##[1:40] vector_req);
endmodule

// ### rtl/mirq_pkg.sv
// Constants, register map and field positions of the interrupt logic.
// Assumes an APB slave with 32-bit data; one register to a word.
//
// Operation
// - Up to fifteen sources, each flag and enable
// - Flags set regardless of any enable
// - Global enable bit 7 gates all requests
// - Enabled pending request vectors after a fixed latency
// - Accept: clear global enable, push, vector 0004h
// - Reset clears global enable
// - Return from handler sets global enable
// - Flags and enables live in stated registers
// - External event latency three or four cycles
// - Pin edge chosen by edge-select bit 6
// - Pin edge sets bit 1; enable bit 4
// - Enabled pin event wakes core from sleep
// - Timer wrap sets bit 2; enable bit 5
// - Upper port change sets bit 0, enabled
// - Only return address saved by hardware
// - Waking source leaves a flag set
// - Wake with global enable loads vector
// - Wake resumes next instruction, then maybe vectors
package mirq_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_A = 8'h04;
  localparam logic [7:0] ADDR_FLAGS_B = 8'h08;
  localparam logic [7:0] ADDR_ENABLES_A = 8'h0C;
  localparam logic [7:0] ADDR_ENABLES_B = 8'h10;
  localparam logic [7:0] ADDR_OPTION = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Control and option register fields
  localparam int BIT_PORT_FLAG = 0;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_EDGE_SEL = 6;
  // Values after reset
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_PERIPH = 8'h00;
  // Vector, peripheral source count and latency
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam int PERIPH_SRC = 12;
  localparam logic [1:0] LAT_CYCLES = 2'h2;
endpackage

// ### rtl/mirq_edge_sync.sv
// Two-flop synchroniser with an edge detector behind the second flop.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps
module mirq_edge_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins and edges
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] prev;
    logic [2:0] fill;
  } mirq_sync_t;

  mirq_sync_t st_ff;
  mirq_sync_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pin_async;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
    nxt_st.fill = {st_ff.fill[1:0], 1'b1};
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Edges stay masked until prev holds a real sample, so a pin that
  // idles high cannot fake an edge right after reset
  assign level = st_ff.sync;
  assign rise = st_ff.sync & ~st_ff.prev & {WIDTH{st_ff.fill[2]}};
  assign fall = ~st_ff.sync & st_ff.prev & {WIDTH{st_ff.fill[2]}};
endmodule

// ### testbench/mirq_core_model.sv
// Core sequencer model: instruction strobes and a return address.
// Assumes the controller pulses vector_req for one clock.
`timescale 1ns/1ps
module mirq_core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Controller side
  input wire logic vector_req,
  input wire logic asleep,
  output logic instr_cycle,
  output logic [12:0] return_pc
);
  logic [1:0] phase_ff;
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Four clocks to an instruction; the core clock stops while asleep
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_ff <= 2'h0;
      instr_cycle <= 1'b0;
      return_pc <= 13'h0123;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      instr_cycle <= (phase_ff == 2'h3) && !asleep;
      // Jump away only after the push, so the pushed value is checkable
      if (vector_req) begin
        return_pc <= return_pc + 13'h0010;
      end
    end
  end
endmodule

// ### testbench/tb.sv
// Self-checking bench of the interrupt controller.
// Assumes the core model and an APB master driven from here.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err;
  logic ext_irq_pin = 1'b0;
  logic [3:0] upper_port = 4'h0;
  logic timer_zero_wrap = 1'b0;
  logic [11:0] periph_event = 12'h000;
  logic return_from_handler = 1'b0;
  logic sleep_enter = 1'b0;
  logic instr_cycle, vector_req, wake_req, asleep;
  logic [12:0] return_pc, vector_addr, stack_push_pc;
  int miscompares = 0;
  int n_checks = 0;
  int nvec = 0;
  int cyc = 0;

  always #2 clk_sys = ~clk_sys;

  mirq_ctrl #(.NUM_PERIPH(12)) dut (.clk_sys, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_irq_pin,
    .upper_port, .timer_zero_wrap, .periph_event, .instr_cycle,
    .return_from_handler, .sleep_enter, .return_pc, .vector_req,
    .vector_addr, .stack_push_pc, .wake_req, .asleep);
  mirq_core_model core (.clk_sys, .reset, .vector_req, .asleep,
    .instr_cycle, .return_pc);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    cyc++;
    if (vector_req === 1'b1) nvec++;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One idle clock after each transfer keeps psel from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic wrc(input logic [7:0] d);
    apb(1'b1, mirq_pkg::ADDR_CONTROL, {24'h0, d});
  endtask

  task automatic rdk(input logic [7:0] e);
    apb(1'b0, mirq_pkg::ADDR_CONTROL, 32'h0);
    chk("control", {24'h0, e}, rd);
  endtask

  task automatic wait_for(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdk(8'h00);
    apb(1'b0, mirq_pkg::ADDR_OPTION, 32'h0);
    chk("option", 32'hFF, rd);
    apb(1'b0, mirq_pkg::ADDR_FLAGS_B, 32'h0);
    chk("flags_b", 32'h0, rd);
    apb(1'b0, mirq_pkg::ADDR_ENABLES_A, 32'h0);
    chk("enables_a", 32'h0, rd);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("vector_addr", 32'h4, {19'h0, vector_addr});
    $display("done reset");
  endtask

  task automatic t_timer;
    int n;
    int v;
    v = nvec;
    timer_zero_wrap <= 1'b1;
    tk(1);
    timer_zero_wrap <= 1'b0;
    tk(20);
    rdk(8'h04);
    chk("no vector", v, nvec);
    wrc(8'hA4);
    wait_for(vector_req, n);
    chk("vector", 1, n < 40);
    chk("pushed pc", {19'h0, return_pc}, {19'h0, stack_push_pc});
    tk(1);
    rdk(8'h24);
    apb(1'b0, mirq_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h3, rd);
    wrc(8'h20);
    return_from_handler <= 1'b1;
    tk(1);
    return_from_handler <= 1'b0;
    v = nvec;
    tk(1);
    rdk(8'hA0);
    tk(20);
    chk("no recursion", v, nvec);
    reset <= 1'b1;
    tk(2);
    reset <= 1'b0;
    tk(3);
    rdk(8'h00);
    $display("done timer");
  endtask

  task automatic t_ext;
    int n;
    apb(1'b1, mirq_pkg::ADDR_OPTION, 32'hFF);
    ext_irq_pin <= 1'b1;
    tk(6);
    rdk(8'h02);
    wrc(8'h00);
    ext_irq_pin <= 1'b0;
    tk(6);
    rdk(8'h00);
    apb(1'b1, mirq_pkg::ADDR_OPTION, 32'hBF);
    ext_irq_pin <= 1'b1;
    tk(6);
    rdk(8'h00);
    wrc(8'h90);
    ext_irq_pin <= 1'b0;
    wait_for(vector_req, n);
    // The vector is seen one edge after the edge that raised it
    chk("latency", 1, n - 1 >= 12 && n - 1 <= 16);
    wrc(8'h10);
    tk(3);
    rdk(8'h10);
    $display("done ext");
  endtask

  task automatic t_periph;
    int n;
    int v;
    apb(1'b1, mirq_pkg::ADDR_ENABLES_B, 32'h1);
    wrc(8'h80);
    v = nvec;
    periph_event <= 12'h041;
    tk(1);
    periph_event <= 12'h000;
    tk(20);
    chk("no vector", v, nvec);
    apb(1'b0, mirq_pkg::ADDR_FLAGS_A, 32'h0);
    chk("flags_a", 32'h1, rd);
    wrc(8'hC0);
    wait_for(vector_req, n);
    chk("vector", 1, n < 40);
    apb(1'b1, mirq_pkg::ADDR_FLAGS_B, 32'h0);
    wrc(8'h00);
    upper_port <= 4'h8;
    tk(6);
    rdk(8'h01);
    wrc(8'h00);
    $display("done periph");
  endtask

  task automatic t_sleep(input logic [7:0] ctl);
    int n;
    apb(1'b1, mirq_pkg::ADDR_OPTION, 32'hFF);
    wrc(ctl);
    ext_irq_pin <= 1'b0;
    tk(6);
    sleep_enter <= 1'b1;
    tk(1);
    sleep_enter <= 1'b0;
    tk(3);
    chk("asleep", 1, asleep);
    // The t_ext and t_periph handlers were never left, so in_handler still reads one
    apb(1'b0, mirq_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h6, rd);
    ext_irq_pin <= 1'b1;
    wait_for(wake_req, n);
    chk("wake", 1, n < 20);
    wait_for(vector_req, n);
    chk("vector", ctl[7], n < 40);
    chk("awake", 0, asleep);
    rdk(8'h12);
    $display("done sleep");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    tk(12);
    reset <= 1'b0;
    tk(4);
    t_reset();
    t_timer();
    t_ext();
    t_periph();
    t_sleep(8'h10);
    t_sleep(8'h90);
    end_of_test();
  end
endmodule
